// [tb/svs_ext_unit.sv]
// svs_ext_unit: external unit model beside the sequencer; strobe frames and pin vectors.
// assumes frame() is called by the bench; strobe stands low outside frames.
`timescale 1ns/1ps
module svs_ext_unit
    import svs_pkg::*;
(
    input  wire logic           busy_out,
    output logic                ext_transfer_strobe,
    output logic [NPORTS*8-1:0] port_in
);
    int   k, cnt;
    logic in_frame;
    initial begin
        k = 0;
        cnt = 0;
        in_frame = 1'b0;
        ext_transfer_strobe = 1'b0;
        port_in = '0;
    end
    // busy only means something inside a frame, so only those moves count
    always @(busy_out) begin
        if (in_frame) cnt++;
    end
    // pins settle before the rising edge and flip mid-high, so each edge sees its own value
    task automatic frame(input int n, output int flips);
        int i;
        cnt = 0;
        in_frame = 1'b1;
        #10;
        for (i = 0; i < n; i++) begin
            k++;
            #80 port_in = {NPORTS{8'h35 + 8'(k) * 8'h1D}};
            #80 ext_transfer_strobe = 1'b1;
            #80 port_in = ~port_in;
            #80 ext_transfer_strobe = 1'b0;
        end
        #400 in_frame = 1'b0;
        flips = cnt;
    endtask : frame
endmodule : svs_ext_unit

// [tb/svs_seq_assertions.sv]
// svs_seq_chk: port-level assertions on the vector sequencer.
// assumes a bind onto svs_sequencer; hready is the slave's own hreadyout.
`timescale 1ns/1ps
module svs_seq_chk (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        ext_transfer_strobe,
    input wire logic        busy_out,
    input wire logic [95:0] port_out,
    input wire logic [11:0] port_oe
);
    logic       wr_d, wr_dd, rd_d, pair_r;
    logic [9:0] sh_r;
    // bus-phase and strobe history; pair_r is odd while a busy pulse is open
    always_ff @(posedge sys_clk) begin
        wr_d  <= hsel & htrans[1] & hready & hwrite;
        rd_d  <= hsel & htrans[1] & hready & ~hwrite;
        wr_dd <= wr_d;
        sh_r  <= {sh_r[8:0], ext_transfer_strobe};
        if (rst)
            pair_r <= 1'b0;
        else if ($changed(busy_out) && !wr_dd)
            pair_r <= ~pair_r;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // a busy move not caused by a polarity write
    sequence s_flip;
        $changed(busy_out) && !wr_dd;
    endsequence
    a_ready_high: assert property (hreadyout == 1'b1)
        else $error("hreadyout low");
    a_reset_quiet: assert property ($fell(rst) |-> port_oe == 12'h000
        && port_out == 96'h0 && busy_out == 1'b0 && hrdata == 32'h0)
        else $error("outputs not idle after reset");
    a_busy_cause: assert property (s_flip |-> sh_r != 10'h000 && sh_r != 10'h3FF)
        else $error("busy moved without a strobe edge");
    a_busy_pulse: assert property (pair_r |=> !pair_r)
        else $error("busy held over one cycle");
    a_busy_gap: assert property (s_flip ##1 s_flip |=> $stable(busy_out)[*2])
        else $error("busy not idle after pulse");
    a_out_hold: assert property ($changed(port_out)
        |-> wr_dd || $changed(busy_out) || $past(rst))
        else $error("port_out moved without cause");
    a_oe_hold: assert property ($changed(port_oe) |-> wr_dd || $past(rst))
        else $error("port_oe moved without write");
    a_rdata_hold: assert property ($changed(hrdata) |-> rd_d || $past(rst))
        else $error("hrdata moved without read");
endmodule : svs_seq_chk

// [tb/testbench.sv]
// testbench: AHB-Lite register traffic plus strobe frames from the unit model.
// assumes svs_pkg, the sequencer, its checker and svs_ext_unit compiled first.
`timescale 1ns/1ps
module testbench;
    import svs_pkg::*;
    logic sys_clk, rst, hsel, hwrite, rd_ph, hresp, busy_out, strb;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, q[$];
    logic [NPORTS*8-1:0] port_in, port_out;
    logic [NPORTS-1:0] port_oe;
    logic [7:0] d1, d2, v;
    wire hready;
    int n_fail = 0, num_checks = 0, fl, i;
    svs_sequencer svs_sequencer_inst (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .ext_transfer_strobe(strb), .busy_out(busy_out), .port_in(port_in),
        .port_out(port_out), .port_oe(port_oe));
    svs_ext_unit svs_ext_unit_inst (.busy_out(busy_out), .ext_transfer_strobe(strb),
        .port_in(port_in));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : cmp
    task automatic end_sim;
        if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    // bounded wait for hready; running out ends the run
    task automatic wready;
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            n_fail++;
            end_sim();
        end
    endtask : wready
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        wready();
        htrans <= 2'b00;
        hwdata <= d;
        rd_ph <= ~w;
        wready();
        rd_ph <= 1'b0;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd
    task automatic ro(input logic [3:0] p, input logic [7:0] x, input logic [31:0] e);
        bus(1'b1, A_PSEL, {28'h0, p});
        bus(1'b1, A_RIDX, {24'h0, x});
        rd(A_READOUT, e);
    endtask : ro
    task automatic run(input int n, input int ef);
        svs_ext_unit_inst.frame(n, fl);
        @(posedge sys_clk);
        cmp("busy flips", ef, fl);
    endtask : run
    function automatic logic [7:0] pv(input int k);
        return 8'h35 + 8'(k) * 8'h1D;
    endfunction : pv
    // read data is taken at the end of the data phase, against the oldest note
    always @(posedge sys_clk) begin
        if (rd_ph && hready === 1'b1) cmp("hrdata", q.pop_front(), hrdata);
    end
    initial begin
        rst = 1'b1;
        hsel = 1'b1;
        htrans = 2'b00;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        rd_ph = 1'b0;
        void'($urandom(32'h9AC93E7B));
        d1 = 8'($urandom);
        d2 = 8'($urandom);
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        cmp("port_oe", 32'(port_oe), 32'h0);
        cmp("hresp", 32'(hresp), 32'h0);
        rd(A_CTRL, 32'h0);
        rd(A_SYNC, 32'h0);
        rd(8'h3C, 32'h0);
        run(2, 0);
        bus(1'b1, A_SYNC, 32'hD);
        rd(A_SYNC, 32'hC);
        bus(1'b1, A_SYNC, 32'h3);
        bus(1'b1, A_PSEL, 32'h1);
        bus(1'b1, A_PCFG, 32'h45);
        rd(A_PCFG, 32'h0);
        bus(1'b1, A_BSEL, 32'h0300007D);
        bus(1'b1, A_PCFG, 32'h49);
        bus(1'b1, A_PSEL, 32'h0);
        bus(1'b1, A_PCFG, 32'h41);
        bus(1'b1, A_PSEL, 32'h2);
        bus(1'b1, A_PCFG, 32'h2002);
        bus(1'b1, A_DATA, {24'h0, d1});
        bus(1'b1, A_DATA, {24'h0, d2});
        rd(A_DATA, 32'h2);
        // readout and sync setup refused once armed; both raise the error flag
        bus(1'b1, A_CTRL, 32'h1);
        rd(A_READOUT, 32'h0);
        bus(1'b1, A_SYNC, 32'h5);
        rd(A_SYNC, 32'h3);
        rd(A_STAT, 32'h5);
        run(4, 8);
        rd(A_CTRL, 32'h0);
        cmp("port2 out", 32'(port_out[23:16]), 32'(d2));
        for (i = 0; i < 4; i++) begin
            v = pv(i + 3);
            ro(4'h0, 8'(i), 32'(v));
            ro(4'h1, 8'(i), {29'h0, v[1], v[7], v[5]});
        end
        bus(1'b1, A_CTRL, 32'h1);
        run(2, 4);
        bus(1'b1, A_CTRL, 32'h0);
        ro(4'h0, 8'h0, 32'(pv(7)));
        bus(1'b1, A_CTRL, 32'h6);
        rd(A_CTRL, 32'h6);
        cmp("busy idle", 32'(busy_out), 32'h1);
        bus(1'b1, A_CTRL, 32'h7);
        run(1, 2);
        bus(1'b1, A_CTRL, 32'h6);
        v = ~pv(9);
        ro(4'h0, 8'h0, 32'(v));
        bus(1'b1, A_PRESET, 32'h1A5);
        rd(A_PRESET, 32'h1A5);
        cmp("port0 out", 32'(port_out[7:0]), 32'hA5);
        bus(1'b1, A_STAT, 32'h4);
        rd(A_PIN, 32'h0);
        rd(A_STAT, 32'h14);
        end_sim();
    end
endmodule : testbench
bind svs_sequencer svs_seq_chk svs_seq_chk_inst (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .ext_transfer_strobe(ext_transfer_strobe), .busy_out(busy_out),
    .port_out(port_out), .port_oe(port_oe));

// [verilog/svs_pkg.sv]
// svs_pkg: constants, register map and state types of the sync port vector sequencer.
// assumes one 25 MHz clock, a word-wide AHB-Lite slave port and 12 byte-wide ports.
package svs_pkg;

    // geometry
    localparam int NPORTS  = 12;
    localparam int PIDX_W  = 4;
    localparam int VCNT_W  = 9;                      // counts 0..256
    localparam int VIDX_W  = 8;                      // buffer index 0..255
    localparam logic [VCNT_W-1:0] VEC_MAX = 9'h100;  // deepest buffer
    localparam logic [PIDX_W-1:0] SYNC_MAX = 4'hC;   // largest sync group

    // register byte addresses (low 8 address bits decoded)
    localparam logic [7:0] A_CTRL     = 8'h00;
    localparam logic [7:0] A_SYNC     = 8'h04;
    localparam logic [7:0] A_STAT     = 8'h08;
    localparam logic [7:0] A_PSEL     = 8'h0C;
    localparam logic [7:0] A_PCFG     = 8'h10;
    localparam logic [7:0] A_BSEL     = 8'h14;
    localparam logic [7:0] A_DATA     = 8'h18;
    localparam logic [7:0] A_RIDX     = 8'h1C;
    localparam logic [7:0] A_READOUT  = 8'h20;       // buffer_readout_request
    localparam logic [7:0] A_PRESET   = 8'h24;
    localparam logic [7:0] A_PIN      = 8'h28;

    // field positions
    localparam int CTRL_ARM      = 0;
    localparam int CTRL_BUSY_NEG = 1;                // busy negative_sense
    localparam int CTRL_EDGE_NEG = 2;                // strobe negative_sense
    localparam int STAT_ARMED    = 0;
    localparam int STAT_BUSY     = 1;
    localparam int STAT_ERR      = 2;
    localparam int STAT_VEC_LSB  = 4;
    localparam int PCFG_DIR_LSB  = 0;
    localparam int PCFG_WID_LSB  = 2;
    localparam int PCFG_CNT_LSB  = 4;
    localparam int PCFG_CLR      = 13;
    localparam int BSEL_NB_LSB   = 24;
    localparam int PRESET_OE     = 8;

    typedef enum logic [1:0] {
        DIR_IDLE      = 2'b00,
        DIR_CAPTURE   = 2'b01,
        DIR_DRIVE     = 2'b10,
        DIR_COMPANION = 2'b11
    } svs_dir_t;

    typedef enum logic [1:0] {
        WID_BYTE = 2'b00,
        WID_WORD = 2'b01,
        WID_BIT  = 2'b10
    } svs_wid_t;

    typedef struct packed {
        svs_dir_t           dir;
        svs_wid_t           wid;
        logic [VCNT_W-1:0]  cnt;       // capture count
        logic [VCNT_W-1:0]  fill;      // entries held
        logic [23:0]        bsel;      // eight 3-bit positions
        logic [3:0]         nb;        // positions used
    } svs_port_cfg_t;

    typedef struct packed {
        logic                        strb_meta;
        logic                        strb_sync;
        logic                        strb_prev;
        logic [NPORTS*8-1:0]         pin_meta;
        logic [NPORTS*8-1:0]         pin_sync;
        logic                        armed;
        logic                        busy;
        logic                        busy_neg;
        logic                        edge_neg;
        logic                        err;
        logic [PIDX_W-1:0]           sync_n;
        logic [PIDX_W-1:0]           psel;
        logic [VCNT_W-1:0]           vec;
        logic [VIDX_W-1:0]           ridx;
        logic [23:0]                 bsel_stage;
        logic [3:0]                  nb_stage;
        svs_port_cfg_t [NPORTS-1:0]  cfg;
        logic [NPORTS-1:0][7:0]      out;
        logic [NPORTS-1:0]           oe;
        logic                        dph;
        logic                        dwr;
        logic [7:0]                  daddr;
        logic [31:0]                 rdata;
    } svs_state_t;

    // all-zero reset: busy positive, rising edge, sync 0, disarmed, tri-stated
    localparam svs_state_t SVS_RESET_STATE = '0;

endpackage : svs_pkg

// [verilog/svs_sequencer.sv]
// svs_sequencer: strobe-driven vector sequencer for a 12-port byte-wide I/O module.
// assumes an AHB-Lite master on sys_clk and an asynchronous strobe and pins from outside.
// What this block does
// - reset: busy positive, rising edge, sync 0, disarmed, all ports tri-stated
// - sync and vector setup accepted only while disarmed
// - setup other than disarm while armed flags error, leaves setup unchanged
// - transfers only while armed; strobe ignored while disarmed
// - after last vector on all sync ports the sequencer disarms itself
// - every arm restarts all buffers at vector one
// - buffer readout refused while armed, allowed once disarmed
// - busy line high when busy if positive, low when busy if negative
// - rising strobe edge triggers if positive sense, falling if negative
// - capture setup clears buffer; each edge stores next entry up to count, max 256
// - port with zero vector count does no transfers
// - word width only on even ports; even low byte, odd high byte
// - leaving word width clears companion and excludes it until redefined
// - bit capture stores only selected bits in the order given
// - sync count 0..12, contiguous from port 0, rest asynchronous
// - ports changing sync status are reinitialised, losing format and data
// - only sync ports take part in strobe transfers and busy
// - disarmed: preset write on sync port accepted, pin read refused
// - driving ports hold last value after a test until rewritten or reset
// - drive setup with clear or from another direction restarts buffer, otherwise appends up to 256
`timescale 1ns/1ps

module svs_sequencer
    import svs_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    input  wire logic                 ext_transfer_strobe,
    output logic                      busy_out,
    input  wire logic [NPORTS*8-1:0]  port_in,
    output logic [NPORTS*8-1:0]       port_out,
    output logic [NPORTS-1:0]         port_oe
);

    svs_state_t s_r;
    svs_state_t s_nxt;

    // buffer storage, one byte lane per port
    logic [7:0]        mem [NPORTS][256];
    logic [NPORTS-1:0] mem_we;
    logic [7:0]        mem_wa [NPORTS];
    logic [7:0]        mem_wd [NPORTS];

    // packs the selected bit positions into the low bits, first selected in bit 0
    function automatic logic [7:0] pack_bits(input logic [7:0] pins,
                                             input logic [23:0] bsel,
                                             input logic [3:0] nb);
        logic [7:0] r;
        r = 8'h00;
        for (int k = 0; k < 8; k++) begin
            if (k < int'(nb)) begin
                r[k] = pins[bsel[3*k +: 3]];
            end
        end
        return r;
    endfunction : pack_bits

    // vectors a port moves in a test: capture count or drive fill
    function automatic logic [VCNT_W-1:0] xfer_cnt(input svs_port_cfg_t c);
        logic [VCNT_W-1:0] r;
        r = '0;
        if (c.dir == DIR_CAPTURE) begin
            r = c.cnt;
        end else if (c.dir == DIR_DRIVE) begin
            r = c.fill;
        end
        return r;
    endfunction : xfer_cnt

    // odd companion follows its even owner's direction and count
    function automatic svs_port_cfg_t eff_cfg(input svs_port_cfg_t [NPORTS-1:0] cfg,
                                              input int p);
        svs_port_cfg_t r;
        r = cfg[p];
        if (cfg[p].dir == DIR_COMPANION && p > 0) begin
            r = cfg[p-1];
        end
        return r;
    endfunction : eff_cfg

    logic              strb_edge;
    logic [VCNT_W-1:0] last_vec;
    svs_port_cfg_t     ec;
    svs_port_cfg_t     newc;
    logic [PIDX_W-1:0] new_sync;
    int                sp;
    logic              setup_ok;
    logic              err_set;

    always_comb begin
        s_nxt    = s_r;
        mem_we   = '0;
        ec       = '0;
        newc     = '0;
        new_sync = '0;
        sp       = 0;
        setup_ok = 1'b0;
        err_set  = 1'b0;
        for (int p = 0; p < NPORTS; p++) begin
            mem_wa[p] = 8'h00;
            mem_wd[p] = 8'h00;
        end

        // two-stage synchronisers; only the second stage is read by logic
        s_nxt.strb_meta = ext_transfer_strobe;
        s_nxt.strb_sync = s_r.strb_meta;
        s_nxt.strb_prev = s_r.strb_sync;
        s_nxt.pin_meta  = port_in;
        s_nxt.pin_sync  = s_r.pin_meta;
        s_nxt.busy      = 1'b0;

        strb_edge = s_r.edge_neg ? (s_r.strb_prev & ~s_r.strb_sync)
                                 : (~s_r.strb_prev & s_r.strb_sync);

        // longest participating buffer decides when the test ends
        last_vec = '0;
        for (int p = 0; p < NPORTS; p++) begin
            ec = eff_cfg(s_r.cfg, p);
            if (p < int'(s_r.sync_n) && xfer_cnt(ec) > last_vec) begin
                last_vec = xfer_cnt(ec);
            end
        end

        // sequencer: one vector per accepted edge, busy for that cycle
        if (s_r.armed && strb_edge && s_r.vec < last_vec) begin
            s_nxt.busy = 1'b1;
            s_nxt.vec  = s_r.vec + 9'h001;
            for (int p = 0; p < NPORTS; p++) begin
                ec = eff_cfg(s_r.cfg, p);
                if (p < int'(s_r.sync_n) && s_r.vec < xfer_cnt(ec)) begin
                    if (ec.dir == DIR_CAPTURE) begin
                        mem_we[p] = 1'b1;
                        mem_wa[p] = s_r.vec[VIDX_W-1:0];
                        mem_wd[p] = (ec.wid == WID_BIT)
                                  ? pack_bits(s_r.pin_sync[8*p +: 8], ec.bsel, ec.nb)
                                  : s_r.pin_sync[8*p +: 8];
                        s_nxt.cfg[p].fill = s_r.vec + 9'h001;
                    end else if (ec.dir == DIR_DRIVE) begin
                        // enables stay the controller's job; only the value moves
                        s_nxt.out[p] = mem[p][s_r.vec[VIDX_W-1:0]];
                    end
                end
            end
        end else if (s_r.armed && !s_r.busy && s_r.vec >= last_vec) begin
            s_nxt.armed = 1'b0;
        end

        // bus address phase: latch access, prepare read data at once
        s_nxt.dph = hsel & htrans[1] & hready;
        if (hsel && htrans[1] && hready) begin
            s_nxt.daddr = haddr[7:0];
            s_nxt.dwr   = hwrite;
            if (!hwrite) begin
                // a write leaves the last read data standing
                s_nxt.rdata = 32'h0000_0000;
                unique case (haddr[7:0])
                    A_CTRL: s_nxt.rdata = {29'h0, s_r.edge_neg, s_r.busy_neg, s_r.armed};
                    A_SYNC: s_nxt.rdata = {28'h0, s_r.sync_n};
                    A_STAT: s_nxt.rdata = {19'h0, s_r.vec, 1'b0, s_r.err,
                                           s_r.busy, s_r.armed};
                    A_PSEL: s_nxt.rdata = {28'h0, s_r.psel};
                    A_PCFG: s_nxt.rdata = {19'h0, s_r.cfg[s_r.psel].cnt,
                                           s_r.cfg[s_r.psel].wid, s_r.cfg[s_r.psel].dir};
                    A_BSEL: s_nxt.rdata = {4'h0, s_r.nb_stage, s_r.bsel_stage};
                    A_DATA: s_nxt.rdata = {23'h0, s_r.cfg[s_r.psel].fill};
                    A_RIDX: s_nxt.rdata = {24'h0, s_r.ridx};
                    A_READOUT: begin
                        if (s_r.armed) begin
                            err_set = 1'b1;
                        end else if ({1'b0, s_r.ridx} < s_r.cfg[s_r.psel].fill) begin
                            s_nxt.rdata = {24'h0, mem[s_r.psel][s_r.ridx]};
                        end
                    end
                    A_PRESET: s_nxt.rdata = {23'h0, s_r.oe[s_r.psel], s_r.out[s_r.psel]};
                    A_PIN: begin
                        if (s_r.psel < s_r.sync_n) begin
                            err_set = 1'b1;
                        end else begin
                            s_nxt.rdata = {24'h0, s_r.pin_sync[8*s_r.psel +: 8]};
                        end
                    end
                    default: s_nxt.rdata = 32'h0000_0000;
                endcase
            end
        end

        // bus data phase: writes; a refused setup only raises the error flag
        if (s_r.dph && s_r.dwr) begin
            unique case (s_r.daddr)
                A_CTRL: begin
                    if (s_r.armed) begin
                        if (!hwdata[CTRL_ARM]) begin
                            s_nxt.armed = 1'b0;
                        end
                        if (hwdata[CTRL_BUSY_NEG] != s_r.busy_neg
                            || hwdata[CTRL_EDGE_NEG] != s_r.edge_neg) begin
                            s_nxt.err = 1'b1;
                        end
                    end else begin
                        s_nxt.busy_neg = hwdata[CTRL_BUSY_NEG];
                        s_nxt.edge_neg = hwdata[CTRL_EDGE_NEG];
                        if (hwdata[CTRL_ARM]) begin
                            s_nxt.armed = 1'b1;
                            s_nxt.vec   = '0;
                        end
                    end
                end
                A_SYNC: begin
                    if (s_r.armed) begin
                        s_nxt.err = 1'b1;
                    end else begin
                        new_sync = (hwdata[PIDX_W-1:0] > SYNC_MAX)
                                 ? SYNC_MAX : hwdata[PIDX_W-1:0];
                        s_nxt.sync_n = new_sync;
                        for (int p = 0; p < NPORTS; p++) begin
                            if ((p < int'(s_r.sync_n)) != (p < int'(new_sync))) begin
                                s_nxt.cfg[p] = '0;
                                s_nxt.out[p] = 8'h00;
                                s_nxt.oe[p]  = 1'b0;
                            end
                        end
                    end
                end
                A_STAT: begin
                    if (hwdata[STAT_ERR]) begin
                        s_nxt.err = 1'b0;                              // write one to clear
                    end
                end
                A_PSEL: s_nxt.psel = hwdata[PIDX_W-1:0];
                A_RIDX: s_nxt.ridx = hwdata[VIDX_W-1:0];
                A_BSEL: begin
                    if (s_r.armed) begin
                        s_nxt.err = 1'b1;
                    end else begin
                        s_nxt.bsel_stage = hwdata[23:0];
                        s_nxt.nb_stage   = (hwdata[27:24] > 4'h8) ? 4'h8 : hwdata[27:24];
                    end
                end
                A_PCFG: begin
                    sp   = int'(s_r.psel);
                    newc = s_r.cfg[sp];
                    newc.dir = svs_dir_t'(hwdata[PCFG_DIR_LSB +: 2]);
                    if (hwdata[PCFG_CLR] || newc.dir == DIR_CAPTURE) begin
                        newc.wid = svs_wid_t'(hwdata[PCFG_WID_LSB +: 2]);
                    end
                    setup_ok = !s_r.armed && s_r.psel < s_r.sync_n
                             && newc.dir != DIR_COMPANION && newc.wid != 2'b11
                             && !(newc.wid == WID_WORD
                                  && (s_r.psel[0] || sp + 1 >= int'(s_r.sync_n)));
                    if (!setup_ok) begin
                        s_nxt.err = 1'b1;
                    end else begin
                        // leaving word width drops the partner of the pair
                        if (s_r.cfg[sp].wid == WID_WORD && newc.wid != WID_WORD
                            && sp + 1 < NPORTS) begin
                            s_nxt.cfg[sp+1] = '0;
                        end
                        if (s_r.cfg[sp].dir == DIR_COMPANION && sp > 0) begin
                            s_nxt.cfg[sp-1] = '0;
                        end
                        newc.cnt  = (hwdata[PCFG_CNT_LSB +: VCNT_W] > VEC_MAX)
                                  ? VEC_MAX : hwdata[PCFG_CNT_LSB +: VCNT_W];
                        newc.bsel = s_r.bsel_stage;
                        newc.nb   = s_r.nb_stage;
                        if (hwdata[PCFG_CLR] || newc.dir == DIR_CAPTURE
                            || s_r.cfg[sp].dir != newc.dir) begin
                            newc.fill = '0;
                        end
                        s_nxt.cfg[sp] = newc;
                        if (newc.wid == WID_WORD) begin
                            s_nxt.cfg[sp+1]      = newc;
                            s_nxt.cfg[sp+1].dir  = DIR_COMPANION;
                        end
                    end
                end
                A_DATA: begin
                    sp = int'(s_r.psel);
                    if (s_r.armed || s_r.psel >= s_r.sync_n
                        || s_r.cfg[sp].dir != DIR_DRIVE || s_r.cfg[sp].fill >= VEC_MAX) begin
                        s_nxt.err = 1'b1;
                    end else begin
                        mem_we[sp] = 1'b1;
                        mem_wa[sp] = s_r.cfg[sp].fill[VIDX_W-1:0];
                        mem_wd[sp] = hwdata[7:0];
                        s_nxt.cfg[sp].fill = s_r.cfg[sp].fill + 9'h001;
                        if (s_r.cfg[sp].wid == WID_WORD && sp + 1 < NPORTS) begin
                            mem_we[sp+1] = 1'b1;
                            mem_wa[sp+1] = s_r.cfg[sp].fill[VIDX_W-1:0];
                            mem_wd[sp+1] = hwdata[15:8];
                            s_nxt.cfg[sp+1].fill = s_r.cfg[sp].fill + 9'h001;
                        end
                    end
                end
                A_PRESET: begin
                    if (s_r.armed) begin
                        s_nxt.err = 1'b1;
                    end else begin
                        s_nxt.out[s_r.psel] = hwdata[7:0];
                        s_nxt.oe[s_r.psel]  = hwdata[PRESET_OE];
                    end
                end
                default: begin
                end
            endcase
        end

        // a refusal in the same cycle as a clear must not be lost: set wins
        if (err_set) begin
            s_nxt.err = 1'b1;
        end
    end

    // state register; all-zero reset covers the power-up defaults
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_r <= SVS_RESET_STATE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // buffers need no reset: fill levels hide stale entries
    always_ff @(posedge sys_clk) begin
        for (int p = 0; p < NPORTS; p++) begin
            if (mem_we[p]) begin
                mem[p][mem_wa[p]] <= mem_wd[p];
            end
        end
    end

    // zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = s_r.rdata;
    assign busy_out  = s_r.busy ^ s_r.busy_neg;
    assign port_out  = s_r.out;
    assign port_oe   = s_r.oe;

endmodule : svs_sequencer
